/* File: src/lcm_pkg.sv */
// Constants for the laser controller mode and configuration register bank.
// Assumes byte-wide register offsets as seen by the serial command decoder.
package lcm_pkg;
  localparam logic [7:0] OFF_MODE       = 8'h80;
  localparam logic [7:0] OFF_TEMP_INDEX = 8'h81;
  localparam logic [7:0] OFF_DAC_A      = 8'h82;
  localparam logic [7:0] OFF_DAC_B      = 8'h83;
  localparam logic [7:0] OFF_CFG_STAT   = 8'h88;
  localparam logic [7:0] OFF_LOGIC_CFG  = 8'h89;

  localparam logic [7:0] MODE_RESET     = 8'h0b;
  localparam logic [7:0] MODE_WMASK     = 8'h0f;
  localparam logic [7:0] INDEX_RESET    = 8'h00;
  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam logic [7:0] CFG_WMASK      = 8'hbf;
  localparam logic [7:0] LOGIC_RESET    = 8'h00;
  localparam logic [7:0] LOGIC_WMASK    = 8'h5d;
  localparam logic [7:0] DAC_RESET      = 8'h00;

  localparam int MODE_TRIP_ON  = 3;
  localparam int MODE_VOLATILE = 2;
  localparam int MODE_TEMP_ON  = 1;
  localparam int MODE_AUTO_IDX = 0;

  localparam int CFG_SOFT_OUT  = 7;
  localparam int CFG_OUT_INV   = 5;
  localparam int CFG_TRIP_HOLD = 4;
  localparam int CFG_B_RANGE   = 3;
  localparam int CFG_A_RANGE   = 2;
  localparam int CFG_ALM_HOLD  = 1;
  localparam int CFG_WRN_HOLD  = 0;

  localparam int LOG_LOSS_SRC  = 6;
  localparam int LOG_ADDR_PROG = 4;
  localparam int LOG_MAP_SEL   = 3;
  localparam int LOG_TXF_POL   = 2;
  localparam int LOG_LOSS_POL  = 0;

  localparam logic [7:0] FIXED_SLAVE_ADDR = 8'ha2;
  localparam logic [7:0] LUT_FIRST        = 8'h80;
  localparam logic [7:0] LUT_LAST         = 8'hc7;
  localparam int         LUT_DEPTH        = 72;

  localparam logic [1:0] FLAG_ALARM = 2'h0;
  localparam logic [1:0] FLAG_WARN  = 2'h1;
  localparam logic [1:0] FLAG_TRIP  = 2'h2;
endpackage : lcm_pkg

/* File: src/lcm_regs.sv */
// Mode and configuration register bank of a laser controller and monitor.
// Assumes a serial bus decoder that presents byte reads and writes, and
// flag clears, as one-cycle strobes synchronous to SYS_CLK.
// Notes on behaviour
// [R1] Mode byte resets to 0Bh; its upper four bits always read zero.
// [R2] Mode bit 3 enables fast-trip comparators and their alarms.
// [R3] Mode bit 2 set makes shadowed locations volatile only.
// [R4] Mode bit 1 clear stops conversions; DACs follow host writes only.
// [R5] Mode bit 1 set runs conversions and loads DACs from lookup tables.
// [R6] Mode bit 0 clear lets host write the index; set computes it.
// [R7] Index byte selects table entry; reads 00h until first conversion or a host write with mode bit 0 clear.
// [R8] First DAC byte holds 8-bit code, overwritten from its table.
// [R9] Second DAC byte holds 8-bit code, updated from its own table.
// [R10] Each DAC output stays undriven until its value has been loaded.
// [R11] Config bit 7 is a software request on the general output.
// [R12] General output is soft OR hardware status, inverted by config bit 5.
// [R13] Config bit 4 latches fast-trip flags until host writes zeros.
// [R14] Config bits 3 and 2 select range of second and first DAC.
// [R15] Config bit 1 latches alarm flags until host writes zeros.
// [R16] Config bit 0 latches warning flags until host writes zeros.
// [R17] Logic bit 6 picks signal loss from monitor threshold or input.
// [R18] Logic bit 4 picks fixed A2h or programmed slave address.
// [R19] Logic bit 3 selects memory map from the next serial command.
// [R20] External transmit fault output is input XOR logic bit 2.
// [R21] Digital signal loss output is input XOR logic bit 0.
// [R22] Each DAC table spans 80h to C7h, addressed by the index.
// [R23] Unused bits read zero and ignore writes.
`timescale 1ns/1ps
module lcm_regs #(
  parameter int MON_W  = 16,
  parameter int ALM_W  = 10,
  parameter int TRIP_W = 3
) (
  // Clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  // Register access from the serial command decoder
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  input  wire logic [7:0]        REG_ADDR,
  input  wire logic [7:0]        REG_WDATA,
  output logic      [7:0]        REG_RDATA,
  output logic                   REG_RVALID,
  input  wire logic              CMD_START,
  // Lookup table programming
  input  wire logic              LUT_WR,
  input  wire logic              LUT_SEL,
  input  wire logic [7:0]        LUT_ADDR,
  input  wire logic [7:0]        LUT_WDATA,
  // Temperature conversion result
  input  wire logic              TEMP_CONV_DONE,
  input  wire logic [7:0]        TEMP_INDEX_IN,
  // Flag conditions and host clears
  input  wire logic [ALM_W-1:0]  ALARM_COND,
  input  wire logic [ALM_W-1:0]  WARN_COND,
  input  wire logic [TRIP_W-1:0] TRIP_COND,
  input  wire logic              FLAG_WR,
  input  wire logic [1:0]        FLAG_SEL,
  input  wire logic [ALM_W-1:0]  FLAG_WDATA,
  // Pins and monitor inputs
  input  wire logic              HW_OUTPUT_STATUS,
  input  wire logic [MON_W-1:0]  THIRD_MONITOR_INPUT,
  input  wire logic [MON_W-1:0]  SIGNAL_LOSS_THRESHOLD,
  input  wire logic              SIGNAL_LOSS_INPUT,
  input  wire logic              TX_FAULT_EXTERNAL,
  input  wire logic              TRANSMIT_FAULT_INPUT,
  input  wire logic [7:0]        MAIN_ADDR_BYTE,
  // Flags
  output logic      [ALM_W-1:0]  ALARM_FLAGS,
  output logic      [ALM_W-1:0]  WARN_FLAGS,
  output logic      [TRIP_W-1:0] TRIP_FLAGS,
  // Control and pin outputs
  output logic                   TRIP_COMPARATOR_ON,
  output logic                   SHADOW_VOLATILE,
  output logic                   TEMP_CONVERSION_ON,
  output logic      [7:0]        SINK_DAC_A,
  output logic      [7:0]        SINK_DAC_B,
  output logic                   SINK_DAC_A_OE,
  output logic                   SINK_DAC_B_OE,
  output logic                   SINK_A_RANGE,
  output logic                   SINK_B_RANGE,
  output logic                   GENERAL_OUTPUT_PIN,
  output logic                   RECEIVE_SIGNAL_LOSS_OUT,
  output logic                   TRANSMIT_FAULT_OUT,
  output logic      [7:0]        SLAVE_ADDR,
  output logic                   MAP_SELECT
);

  logic [7:0]  mode_q;
  logic [7:0]  index_q;
  logic [7:0]  dac_a_q;
  logic [7:0]  dac_b_q;
  logic        recall_a_q;
  logic        recall_b_q;
  logic [7:0]  cfg_q;
  logic [7:0]  logic_q;
  logic        lut_load_q;
  logic [7:0]  lut_a [lcm_pkg::LUT_DEPTH];
  logic [7:0]  lut_b [lcm_pkg::LUT_DEPTH];
  logic [6:0]  lut_ptr;
  logic [7:0]  lut_off;
  logic        trip_on;
  logic        temp_on;
  logic        auto_idx;
  logic        conv_take;
  logic [ALM_W-1:0]  alm_d;
  logic [ALM_W-1:0]  wrn_d;
  logic [TRIP_W-1:0] trip_d;
  logic [TRIP_W-1:0] trip_cond_g;
  logic [ALM_W-1:0]  clr_alm;
  logic [ALM_W-1:0]  clr_wrn;
  logic [TRIP_W-1:0] clr_trip;

  assign trip_on   = mode_q[lcm_pkg::MODE_TRIP_ON];
  assign temp_on   = mode_q[lcm_pkg::MODE_TEMP_ON];
  assign auto_idx  = mode_q[lcm_pkg::MODE_AUTO_IDX];
  assign conv_take = TEMP_CONV_DONE && temp_on && auto_idx; // [R4] [R6]

  // Mode byte
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      mode_q <= lcm_pkg::MODE_RESET; // [R1]
    end else if (REG_WR && REG_ADDR == lcm_pkg::OFF_MODE) begin
      mode_q <= REG_WDATA & lcm_pkg::MODE_WMASK; // [R1] [R23]
    end
  end

  // Temperature index byte
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      index_q <= lcm_pkg::INDEX_RESET; // [R7]
    end else if (conv_take) begin
      index_q <= TEMP_INDEX_IN; // [R6] [R7]
    end else if (!auto_idx && REG_WR && REG_ADDR == lcm_pkg::OFF_TEMP_INDEX) begin
      index_q <= REG_WDATA; // [R6]
    end
  end

  // Lookup tables, entries beyond the last are clamped to the last
  assign lut_off = (index_q > (lcm_pkg::LUT_LAST - lcm_pkg::LUT_FIRST)) ?
                   (lcm_pkg::LUT_LAST - lcm_pkg::LUT_FIRST) : index_q;
  assign lut_ptr = lut_off[6:0]; // [R22]

  generate
    for (genvar i = 0; i < lcm_pkg::LUT_DEPTH; i++) begin : g_lut
      always_ff @(posedge SYS_CLK) begin
        if (LUT_WR && LUT_ADDR == lcm_pkg::LUT_FIRST + 8'(i)) begin // [R22]
          if (LUT_SEL) begin
            lut_b[i] <= LUT_WDATA;
          end else begin
            lut_a[i] <= LUT_WDATA;
          end
        end
      end
    end
  endgenerate

  // Table load follows each accepted conversion, or manual index write while conversions run
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      lut_load_q <= 1'b0;
    end else begin
      lut_load_q <= temp_on && (conv_take ||
                    (!auto_idx && REG_WR && REG_ADDR == lcm_pkg::OFF_TEMP_INDEX)); // [R5]
    end
  end

  // DAC value bytes
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      dac_a_q    <= lcm_pkg::DAC_RESET;
      recall_a_q <= 1'b0;
    end else if (lut_load_q && temp_on) begin
      dac_a_q    <= lut_a[lut_ptr]; // [R5] [R8]
      recall_a_q <= 1'b1; // [R10]
    end else if (REG_WR && REG_ADDR == lcm_pkg::OFF_DAC_A) begin
      dac_a_q    <= REG_WDATA; // [R4] [R8]
      recall_a_q <= 1'b1; // [R10]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      dac_b_q    <= lcm_pkg::DAC_RESET;
      recall_b_q <= 1'b0;
    end else if (lut_load_q && temp_on) begin
      dac_b_q    <= lut_b[lut_ptr]; // [R5] [R9]
      recall_b_q <= 1'b1; // [R10]
    end else if (REG_WR && REG_ADDR == lcm_pkg::OFF_DAC_B) begin
      dac_b_q    <= REG_WDATA; // [R4] [R9]
      recall_b_q <= 1'b1; // [R10]
    end
  end

  // Configuration bytes
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cfg_q <= lcm_pkg::CFG_RESET;
    end else if (REG_WR && REG_ADDR == lcm_pkg::OFF_CFG_STAT) begin
      cfg_q <= REG_WDATA & lcm_pkg::CFG_WMASK; // [R23]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      logic_q <= lcm_pkg::LOGIC_RESET;
    end else if (REG_WR && REG_ADDR == lcm_pkg::OFF_LOGIC_CFG) begin
      logic_q <= REG_WDATA & lcm_pkg::LOGIC_WMASK; // [R23]
    end
  end

  // Read port, unmapped offsets read zero
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        case (REG_ADDR)
          lcm_pkg::OFF_MODE:       REG_RDATA <= mode_q; // [R1]
          lcm_pkg::OFF_TEMP_INDEX: REG_RDATA <= index_q; // [R7]
          lcm_pkg::OFF_DAC_A:      REG_RDATA <= dac_a_q;
          lcm_pkg::OFF_DAC_B:      REG_RDATA <= dac_b_q;
          lcm_pkg::OFF_CFG_STAT:   REG_RDATA <= cfg_q; // [R23]
          lcm_pkg::OFF_LOGIC_CFG:  REG_RDATA <= logic_q; // [R23]
          default:                 REG_RDATA <= 8'h00;
        endcase
      end
    end
  end

  // Flag latching, a new event wins over a clear in the same cycle
  assign clr_alm     = (FLAG_WR && FLAG_SEL == lcm_pkg::FLAG_ALARM) ? ~FLAG_WDATA : '0;
  assign clr_wrn     = (FLAG_WR && FLAG_SEL == lcm_pkg::FLAG_WARN) ? ~FLAG_WDATA : '0;
  assign clr_trip    = (FLAG_WR && FLAG_SEL == lcm_pkg::FLAG_TRIP) ? ~FLAG_WDATA[TRIP_W-1:0] : '0;
  assign trip_cond_g = trip_on ? TRIP_COND : '0; // [R2]
  assign alm_d  = cfg_q[lcm_pkg::CFG_ALM_HOLD]  ? ((ALARM_FLAGS & ~clr_alm) | ALARM_COND) : ALARM_COND; // [R15]
  assign wrn_d  = cfg_q[lcm_pkg::CFG_WRN_HOLD]  ? ((WARN_FLAGS & ~clr_wrn) | WARN_COND) : WARN_COND; // [R16]
  assign trip_d = cfg_q[lcm_pkg::CFG_TRIP_HOLD] ? ((TRIP_FLAGS & ~clr_trip) | trip_cond_g) : trip_cond_g; // [R13]

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ALARM_FLAGS <= '0;
      WARN_FLAGS  <= '0;
      TRIP_FLAGS  <= '0;
    end else begin
      ALARM_FLAGS <= alm_d;
      WARN_FLAGS  <= wrn_d;
      TRIP_FLAGS  <= trip_on ? trip_d : '0; // [R2]
    end
  end

  // Mode and range outputs
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      TRIP_COMPARATOR_ON <= 1'b0;
      SHADOW_VOLATILE    <= 1'b0;
      TEMP_CONVERSION_ON <= 1'b0;
      SINK_A_RANGE       <= 1'b0;
      SINK_B_RANGE       <= 1'b0;
    end else begin
      TRIP_COMPARATOR_ON <= trip_on; // [R2]
      SHADOW_VOLATILE    <= mode_q[lcm_pkg::MODE_VOLATILE]; // [R3]
      TEMP_CONVERSION_ON <= temp_on; // [R4] [R5]
      SINK_A_RANGE       <= cfg_q[lcm_pkg::CFG_A_RANGE]; // [R14]
      SINK_B_RANGE       <= cfg_q[lcm_pkg::CFG_B_RANGE]; // [R14]
    end
  end

  // DAC drive, undriven until a value is loaded
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      SINK_DAC_A    <= 8'h00;
      SINK_DAC_B    <= 8'h00;
      SINK_DAC_A_OE <= 1'b0;
      SINK_DAC_B_OE <= 1'b0;
    end else begin
      SINK_DAC_A    <= dac_a_q;
      SINK_DAC_B    <= dac_b_q;
      SINK_DAC_A_OE <= recall_a_q; // [R10]
      SINK_DAC_B_OE <= recall_b_q; // [R10]
    end
  end

  // Pin logic
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      GENERAL_OUTPUT_PIN      <= 1'b0;
      RECEIVE_SIGNAL_LOSS_OUT <= 1'b0;
      TRANSMIT_FAULT_OUT      <= 1'b0;
    end else begin
      GENERAL_OUTPUT_PIN <= cfg_q[lcm_pkg::CFG_OUT_INV] ^
                            (cfg_q[lcm_pkg::CFG_SOFT_OUT] | HW_OUTPUT_STATUS); // [R11] [R12]
      if (logic_q[lcm_pkg::LOG_LOSS_SRC]) begin
        RECEIVE_SIGNAL_LOSS_OUT <= SIGNAL_LOSS_INPUT ^ logic_q[lcm_pkg::LOG_LOSS_POL]; // [R17] [R21]
      end else begin
        RECEIVE_SIGNAL_LOSS_OUT <= THIRD_MONITOR_INPUT < SIGNAL_LOSS_THRESHOLD; // [R17]
      end
      if (TX_FAULT_EXTERNAL) begin
        TRANSMIT_FAULT_OUT <= TRANSMIT_FAULT_INPUT ^ logic_q[lcm_pkg::LOG_TXF_POL]; // [R20]
      end else begin
        TRANSMIT_FAULT_OUT <= |TRIP_FLAGS;
      end
    end
  end

  // Serial addressing
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      SLAVE_ADDR <= lcm_pkg::FIXED_SLAVE_ADDR;
      MAP_SELECT <= 1'b0;
    end else begin
      SLAVE_ADDR <= logic_q[lcm_pkg::LOG_ADDR_PROG] ? MAIN_ADDR_BYTE : lcm_pkg::FIXED_SLAVE_ADDR; // [R18]
      if (CMD_START) begin
        MAP_SELECT <= logic_q[lcm_pkg::LOG_MAP_SEL]; // [R19]
      end
    end
  end

  mode_upper_zero_a : assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R1]
    mode_q[7:4] == 4'h0)
    else $error("mode upper bits not zero");
  mode_reset_val_a : assert property (@(posedge SYS_CLK) // [R1]
    !RST_N |=> mode_q == 8'h0b)
    else $error("mode reset value wrong");
  trip_gate_a : assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R2]
    !trip_on |=> TRIP_FLAGS == '0)
    else $error("trip flag while comparators off");
  index_manual_a : assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R6]
    (auto_idx && !TEMP_CONV_DONE) |=> $stable(index_q))
    else $error("index moved in auto mode");
  dac_hold_a : assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R4]
    (!temp_on && !REG_WR && !lut_load_q) |=> $stable(dac_a_q))
    else $error("dac changed without write");
  dac_oe_a : assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R10]
    !recall_a_q |=> !SINK_DAC_A_OE)
    else $error("dac driven before load");
  gen_out_a : assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R12]
    1'b1 |=> GENERAL_OUTPUT_PIN == ($past(cfg_q[5]) ^ ($past(cfg_q[7]) | $past(HW_OUTPUT_STATUS))))
    else $error("general output wrong");
  alarm_hold_a : assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R15]
    (cfg_q[1] && ALARM_FLAGS[0] && !(FLAG_WR && FLAG_SEL == 2'h0)) |=> ALARM_FLAGS[0])
    else $error("held alarm lost");
  warn_follow_a : assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R16]
    !cfg_q[0] |=> WARN_FLAGS == $past(WARN_COND))
    else $error("warning not following");
  txf_pol_a : assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R20]
    TX_FAULT_EXTERNAL |=> TRANSMIT_FAULT_OUT == ($past(TRANSMIT_FAULT_INPUT) ^ $past(logic_q[2])))
    else $error("tx fault polarity wrong");
  addr_fixed_a : assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R18]
    !logic_q[4] |=> SLAVE_ADDR == 8'ha2)
    else $error("slave address not fixed");
  map_sel_a : assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R19]
    !CMD_START |=> $stable(MAP_SELECT))
    else $error("map changed without command");
  index_reset_a : assert property (@(posedge SYS_CLK) // [R7]
    !RST_N |=> index_q == lcm_pkg::INDEX_RESET)
    else $error("index reset value wrong");
  dac_b_oe_a : assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R10]
    !recall_b_q |=> !SINK_DAC_B_OE)
    else $error("second dac driven before load");
  trip_hold_a : assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R13]
    (cfg_q[lcm_pkg::CFG_TRIP_HOLD] && trip_on && !(FLAG_WR && FLAG_SEL == lcm_pkg::FLAG_TRIP))
    |=> (TRIP_FLAGS & $past(TRIP_FLAGS)) == $past(TRIP_FLAGS))
    else $error("held trip flag lost");
  alarm_follow_a : assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R15]
    !cfg_q[lcm_pkg::CFG_ALM_HOLD] |=> ALARM_FLAGS == $past(ALARM_COND))
    else $error("alarm not following");
  warn_hold_a : assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R16]
    (cfg_q[lcm_pkg::CFG_WRN_HOLD] && !(FLAG_WR && FLAG_SEL == lcm_pkg::FLAG_WARN))
    |=> (WARN_FLAGS & $past(WARN_FLAGS)) == $past(WARN_FLAGS))
    else $error("held warning lost");
  loss_monitor_a : assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R17]
    !logic_q[lcm_pkg::LOG_LOSS_SRC] |=>
    RECEIVE_SIGNAL_LOSS_OUT == $past(THIRD_MONITOR_INPUT < SIGNAL_LOSS_THRESHOLD))
    else $error("monitor loss compare wrong");
  loss_input_a : assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R21]
    logic_q[lcm_pkg::LOG_LOSS_SRC] |=> RECEIVE_SIGNAL_LOSS_OUT ==
    ($past(SIGNAL_LOSS_INPUT) ^ $past(logic_q[lcm_pkg::LOG_LOSS_POL])))
    else $error("loss input polarity wrong");

endmodule : lcm_regs

/* File: test/lcm_host.sv */
// Host model: turns serial commands into byte strobes for the register bank.
// Assumes one clock domain; the bench calls its tasks hierarchically.
`timescale 1ns/1ps
module lcm_host (
  // Clock
  input  wire logic       SYS_CLK,
  // Register strobes
  output logic            REG_WR,
  output logic            REG_RD,
  output logic      [7:0] REG_ADDR,
  output logic      [7:0] REG_WDATA,
  output logic            CMD_START,
  // Read answer
  input  wire logic [7:0] REG_RDATA,
  input  wire logic       REG_RVALID
);
  initial begin
    REG_WR    = 1'b0;
    REG_RD    = 1'b0;
    REG_ADDR  = 8'h00;
    REG_WDATA = 8'h00;
    CMD_START = 1'b0;
  end

  // Released lines show the inverse of their last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge SYS_CLK);
    REG_WR    <= 1'b0;
    REG_ADDR  <= ~a;
    REG_WDATA <= ~d;
  endtask : wr

  // Unknown data back when no answer comes in time
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int i;
    @(posedge SYS_CLK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge SYS_CLK);
    REG_RD   <= 1'b0;
    REG_ADDR <= ~a;
    #1;
    for (i = 0; i < 4 && REG_RVALID !== 1'b1; i++) begin
      @(posedge SYS_CLK);
      #1;
    end
    d = (REG_RVALID === 1'b1) ? REG_RDATA : 8'hxx;
  endtask : rd

  // Start of a new serial command
  task automatic cmd();
    @(posedge SYS_CLK);
    CMD_START <= 1'b1;
    @(posedge SYS_CLK);
    CMD_START <= 1'b0;
  endtask : cmd
endmodule : lcm_host

/* File: test/lcm_regs_tb.sv */
// Self-checking bench for the mode and configuration register bank.
// Assumes the host model drives the register strobes; bench drives the rest.
`timescale 1ns/1ps
module lcm_regs_tb;
  logic       SYS_CLK, RST_N, REG_WR, REG_RD, REG_RVALID, CMD_START, LUT_WR, LUT_SEL, TEMP_CONV_DONE;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, LUT_ADDR, LUT_WDATA, TEMP_INDEX_IN, MAIN_ADDR_BYTE;
  logic [9:0] ALARM_COND, WARN_COND, FLAG_WDATA, ALARM_FLAGS, WARN_FLAGS;
  logic [2:0] TRIP_COND, TRIP_FLAGS;
  logic [1:0] FLAG_SEL;
  logic       FLAG_WR, HW_OUTPUT_STATUS, SIGNAL_LOSS_INPUT, TX_FAULT_EXTERNAL, TRANSMIT_FAULT_INPUT;
  logic [15:0] THIRD_MONITOR_INPUT, SIGNAL_LOSS_THRESHOLD;
  logic       TRIP_COMPARATOR_ON, SHADOW_VOLATILE, TEMP_CONVERSION_ON, SINK_DAC_A_OE, SINK_DAC_B_OE;
  logic [7:0] SINK_DAC_A, SINK_DAC_B, SLAVE_ADDR;
  logic       SINK_A_RANGE, SINK_B_RANGE, GENERAL_OUTPUT_PIN, RECEIVE_SIGNAL_LOSS_OUT;
  logic       TRANSMIT_FAULT_OUT, MAP_SELECT;
  int         miscompares, checks_done, i;

  lcm_host i_host (.SYS_CLK(SYS_CLK), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .CMD_START(CMD_START), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID));

  lcm_regs i_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .CMD_START(CMD_START), .LUT_WR(LUT_WR), .LUT_SEL(LUT_SEL), .LUT_ADDR(LUT_ADDR),
    .LUT_WDATA(LUT_WDATA), .TEMP_CONV_DONE(TEMP_CONV_DONE), .TEMP_INDEX_IN(TEMP_INDEX_IN),
    .ALARM_COND(ALARM_COND), .WARN_COND(WARN_COND), .TRIP_COND(TRIP_COND), .FLAG_WR(FLAG_WR),
    .FLAG_SEL(FLAG_SEL), .FLAG_WDATA(FLAG_WDATA), .HW_OUTPUT_STATUS(HW_OUTPUT_STATUS),
    .THIRD_MONITOR_INPUT(THIRD_MONITOR_INPUT), .SIGNAL_LOSS_THRESHOLD(SIGNAL_LOSS_THRESHOLD),
    .SIGNAL_LOSS_INPUT(SIGNAL_LOSS_INPUT), .TX_FAULT_EXTERNAL(TX_FAULT_EXTERNAL),
    .TRANSMIT_FAULT_INPUT(TRANSMIT_FAULT_INPUT), .MAIN_ADDR_BYTE(MAIN_ADDR_BYTE),
    .ALARM_FLAGS(ALARM_FLAGS), .WARN_FLAGS(WARN_FLAGS), .TRIP_FLAGS(TRIP_FLAGS),
    .TRIP_COMPARATOR_ON(TRIP_COMPARATOR_ON), .SHADOW_VOLATILE(SHADOW_VOLATILE),
    .TEMP_CONVERSION_ON(TEMP_CONVERSION_ON), .SINK_DAC_A(SINK_DAC_A), .SINK_DAC_B(SINK_DAC_B),
    .SINK_DAC_A_OE(SINK_DAC_A_OE), .SINK_DAC_B_OE(SINK_DAC_B_OE), .SINK_A_RANGE(SINK_A_RANGE),
    .SINK_B_RANGE(SINK_B_RANGE), .GENERAL_OUTPUT_PIN(GENERAL_OUTPUT_PIN),
    .RECEIVE_SIGNAL_LOSS_OUT(RECEIVE_SIGNAL_LOSS_OUT), .TRANSMIT_FAULT_OUT(TRANSMIT_FAULT_OUT),
    .SLAVE_ADDR(SLAVE_ADDR), .MAP_SELECT(MAP_SELECT));

  initial begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask : cyc

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(a, d);
    chk(d, e);
  endtask : rc

  task automatic lut(input logic s, input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    LUT_WR    <= 1'b1;
    LUT_SEL   <= s;
    LUT_ADDR  <= a;
    LUT_WDATA <= d;
    @(posedge SYS_CLK);
    LUT_WR    <= 1'b0;
  endtask : lut

  task automatic conv(input logic [7:0] x);
    @(posedge SYS_CLK);
    TEMP_CONV_DONE <= 1'b1;
    TEMP_INDEX_IN  <= x;
    @(posedge SYS_CLK);
    TEMP_CONV_DONE <= 1'b0;
    cyc(3);
  endtask : conv

  task automatic cond(input logic [9:0] a, input logic [9:0] w, input logic [2:0] t);
    @(posedge SYS_CLK);
    ALARM_COND <= a;
    WARN_COND  <= w;
    TRIP_COND  <= t;
  endtask : cond

  task automatic clr(input logic [1:0] s, input logic [9:0] d);
    @(posedge SYS_CLK);
    FLAG_WR    <= 1'b1;
    FLAG_SEL   <= s;
    FLAG_WDATA <= d;
    @(posedge SYS_CLK);
    FLAG_WR    <= 1'b0;
  endtask : clr

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    {LUT_WR, LUT_SEL, TEMP_CONV_DONE, FLAG_WR, HW_OUTPUT_STATUS, SIGNAL_LOSS_INPUT} = '0;
    {TX_FAULT_EXTERNAL, TRANSMIT_FAULT_INPUT, FLAG_SEL, FLAG_WDATA} = '0;
    {LUT_ADDR, LUT_WDATA, TEMP_INDEX_IN, ALARM_COND, WARN_COND, TRIP_COND} = '0;
    {THIRD_MONITOR_INPUT, SIGNAL_LOSS_THRESHOLD} = '0;
    MAIN_ADDR_BYTE = 8'h5c;
    RST_N = 1'b0;
    repeat (6) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    cyc(2);
    rc(lcm_pkg::OFF_MODE, 8'h0b);
    rc(lcm_pkg::OFF_TEMP_INDEX, 8'h00);
    rc(lcm_pkg::OFF_CFG_STAT, 8'h00);
    rc(lcm_pkg::OFF_LOGIC_CFG, 8'h00);
    rc(8'h84, 8'h00);
    chk(SLAVE_ADDR, 8'ha2);
    chk({SINK_DAC_A_OE, SINK_DAC_B_OE}, 2'b00);
    chk({TRIP_COMPARATOR_ON, SHADOW_VOLATILE, TEMP_CONVERSION_ON}, 3'b101);
    // Table entries for index 5 and the last entry
    lut(1'b0, 8'h85, 8'h5a);
    lut(1'b1, 8'h85, 8'ha5);
    lut(1'b0, 8'hc7, 8'h3c);
    lut(1'b1, 8'hc7, 8'hc3);
    conv(8'h05);
    rc(lcm_pkg::OFF_TEMP_INDEX, 8'h05);
    chk({SINK_DAC_A, SINK_DAC_B}, 16'h5aa5);
    chk({SINK_DAC_A_OE, SINK_DAC_B_OE}, 2'b11);
    conv(8'h64);
    chk({SINK_DAC_A, SINK_DAC_B}, 16'h3cc3);
    i_host.wr(lcm_pkg::OFF_TEMP_INDEX, 8'h02);
    rc(lcm_pkg::OFF_TEMP_INDEX, 8'h64);
    // Manual DAC control, conversions stopped
    i_host.wr(lcm_pkg::OFF_MODE, 8'hf4);
    rc(lcm_pkg::OFF_MODE, 8'h04);
    chk({TRIP_COMPARATOR_ON, SHADOW_VOLATILE, TEMP_CONVERSION_ON}, 3'b010);
    i_host.wr(lcm_pkg::OFF_DAC_A, 8'h33);
    i_host.wr(lcm_pkg::OFF_DAC_B, 8'h44);
    conv(8'h05);
    chk({SINK_DAC_A, SINK_DAC_B}, 16'h3344);
    rc(lcm_pkg::OFF_TEMP_INDEX, 8'h64);
    i_host.wr(lcm_pkg::OFF_TEMP_INDEX, 8'h05);
    rc(lcm_pkg::OFF_TEMP_INDEX, 8'h05);
    rc(lcm_pkg::OFF_DAC_A, 8'h33);
    // Manual index with conversions on reloads from the tables
    i_host.wr(lcm_pkg::OFF_MODE, 8'h0a);
    i_host.wr(lcm_pkg::OFF_TEMP_INDEX, 8'h05);
    cyc(3);
    chk({SINK_DAC_A, SINK_DAC_B}, 16'h5aa5);
    i_host.wr(lcm_pkg::OFF_CFG_STAT, 8'hff);
    rc(lcm_pkg::OFF_CFG_STAT, 8'hbf);
    chk({SINK_B_RANGE, SINK_A_RANGE, GENERAL_OUTPUT_PIN}, 3'b110);
    i_host.wr(lcm_pkg::OFF_CFG_STAT, 8'h08);
    cyc(2);
    chk({SINK_B_RANGE, SINK_A_RANGE}, 2'b10);
    for (i = 0; i < 8; i++) begin
      @(posedge SYS_CLK);
      HW_OUTPUT_STATUS <= i[0];
      i_host.wr(lcm_pkg::OFF_CFG_STAT, {i[1], 1'b0, i[2], 5'h00});
      cyc(2);
      chk(GENERAL_OUTPUT_PIN, (i[1] | i[0]) ^ i[2]);
    end
    // Latched flags hold until written to zero
    i_host.wr(lcm_pkg::OFF_CFG_STAT, 8'h13);
    cond(10'h2a5, 10'h15a, 3'h5);
    cond(10'h000, 10'h000, 3'h0);
    cyc(2);
    chk({ALARM_FLAGS, WARN_FLAGS, TRIP_FLAGS}, {10'h2a5, 10'h15a, 3'h5});
    clr(lcm_pkg::FLAG_ALARM, 10'h0f0);
    cyc(1);
    chk(ALARM_FLAGS, 10'h0a0);
    clr(lcm_pkg::FLAG_WARN, 10'h000);
    clr(lcm_pkg::FLAG_TRIP, 10'h000);
    cyc(1);
    chk({WARN_FLAGS, TRIP_FLAGS}, 13'h0000);
    // Unlatched flags follow their conditions
    i_host.wr(lcm_pkg::OFF_CFG_STAT, 8'h00);
    cond(10'h2a5, 10'h15a, 3'h5);
    cyc(2);
    chk({ALARM_FLAGS, WARN_FLAGS, TRIP_FLAGS}, {10'h2a5, 10'h15a, 3'h5});
    cond(10'h000, 10'h000, 3'h0);
    cyc(2);
    chk({ALARM_FLAGS, WARN_FLAGS, TRIP_FLAGS}, 23'h0);
    i_host.wr(lcm_pkg::OFF_MODE, 8'h03);
    cond(10'h000, 10'h000, 3'h7);
    cyc(2);
    chk(TRIP_FLAGS, 3'h0);
    // Logic configuration and pin polarity
    i_host.wr(lcm_pkg::OFF_LOGIC_CFG, 8'hff);
    rc(lcm_pkg::OFF_LOGIC_CFG, 8'h5d);
    chk({SLAVE_ADDR, 7'h00, MAP_SELECT}, 16'h5c00);
    i_host.cmd();
    cyc(1);
    chk(MAP_SELECT, 1'b1);
    @(posedge SYS_CLK);
    TX_FAULT_EXTERNAL <= 1'b1;
    cyc(2);
    chk({TRANSMIT_FAULT_OUT, RECEIVE_SIGNAL_LOSS_OUT}, 2'b11);
    @(posedge SYS_CLK);
    {TRANSMIT_FAULT_INPUT, SIGNAL_LOSS_INPUT} <= 2'b11;
    cyc(2);
    chk({TRANSMIT_FAULT_OUT, RECEIVE_SIGNAL_LOSS_OUT}, 2'b00);
    i_host.wr(lcm_pkg::OFF_LOGIC_CFG, 8'h00);
    @(posedge SYS_CLK);
    THIRD_MONITOR_INPUT   <= 16'h0100;
    SIGNAL_LOSS_THRESHOLD <= 16'h0101;
    cyc(2);
    chk({TRANSMIT_FAULT_OUT, RECEIVE_SIGNAL_LOSS_OUT}, 2'b11);
    @(posedge SYS_CLK);
    THIRD_MONITOR_INPUT <= 16'h0101;
    cyc(2);
    chk(RECEIVE_SIGNAL_LOSS_OUT, 1'b0);
    i_host.cmd();
    cyc(1);
    chk({SLAVE_ADDR, 7'h00, MAP_SELECT}, 16'ha200);
    tally_and_finish();
  end
endmodule : lcm_regs_tb
